// ### rtl/lmw_pkg.sv
// package: register map, field layout, opcodes and sizes for the write command block
package lmw_pkg;
    // wishbone byte offsets (word aligned)
    localparam logic [7:0] OFS_DATA    = 8'h00;
    localparam logic [7:0] OFS_FEAT    = 8'h04;
    localparam logic [7:0] OFS_COUNT   = 8'h08;
    localparam logic [7:0] OFS_ADDR_LO = 8'h0C;
    localparam logic [7:0] OFS_ADDR_MD = 8'h10;
    localparam logic [7:0] OFS_ADDR_HI = 8'h14;
    localparam logic [7:0] OFS_DEVICE  = 8'h18;
    localparam logic [7:0] OFS_CMD     = 8'h1C;
    localparam logic [7:0] OFS_ERROR   = 8'h20;
    localparam logic [7:0] OFS_STATUS  = 8'h24;
    localparam logic [7:0] OFS_MULT    = 8'h28;
    localparam logic [7:0] OFS_LOGCTL  = 8'h2C;
    localparam logic [7:0] OFS_COMMIT  = 8'h30;
    localparam logic [7:0] OFS_EVENTS  = 8'h34;
    // opcodes
    localparam logic [7:0] CMD_WRITE_LOG  = 8'h3F;
    localparam logic [7:0] CMD_WRITE_MULT = 8'hC5;
    localparam logic [7:0] CMD_WRITE_MEXT = 8'h39;
    // field positions
    localparam int ERR_ABT_BIT = 2;
    localparam int ST_BSY_BIT  = 7;
    localparam int ST_RDY_BIT  = 6;
    localparam int ST_DSC_BIT  = 4;
    localparam int ST_DRQ_BIT  = 3;
    localparam int ST_ERR_BIT  = 0;
    localparam int DEV_LBA_BIT = 6;
    // reset values
    localparam logic [7:0] STATUS_RST = 8'h50;
    localparam logic [7:0] MULT_RST   = 8'h01;
    // sizes
    localparam int WORDS_PER_SECTOR = 256;  // 512 bytes in 16-bit words
    localparam int LOG_SECTORS      = 4;    // per log page kept on chip
    localparam logic [8:0] MULT_ZERO_COUNT = 9'h100;

    typedef enum logic [3:0] {
        LMW_IDLE = 4'b0001,
        LMW_XFER = 4'b0010,
        LMW_DONE = 4'b0100,
        LMW_ABRT = 4'b1000
    } lmw_state_t;

    // wishbone request carrier
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } lmw_wb_req_t;
endpackage : lmw_pkg

// ### rtl/lmw_addr_step.sv
// address stepper: advances a chs or 28-bit lba location by one sector
`timescale 1ns/100ps
module lmw_addr_step #(
    parameter logic [7:0] MAX_SECT = 8'h3F,
    parameter logic [3:0] MAX_HEAD = 4'hF
) (
    input  wire logic        lba_mode,
    input  wire logic [7:0]  addr_lo,
    input  wire logic [7:0]  addr_md,
    input  wire logic [7:0]  addr_hi,
    input  wire logic [3:0]  head,
    output logic      [7:0]  next_lo,
    output logic      [7:0]  next_md,
    output logic      [7:0]  next_hi,
    output logic      [3:0]  next_head
);
    logic [27:0] lba;
    logic [15:0] cyl;

    // lba wraps at 28 bits; chs walks sector, then head, then cylinder
    always_comb begin
        lba       = {head, addr_hi, addr_md, addr_lo} + 28'h0000001;
        cyl       = {addr_hi, addr_md};
        next_lo   = addr_lo;
        next_md   = addr_md;
        next_hi   = addr_hi;
        next_head = head;
        if (lba_mode) begin
            {next_head, next_hi, next_md, next_lo} = lba;
        end else if (addr_lo < MAX_SECT) begin
            next_lo = addr_lo + 8'h01;
        end else begin
            next_lo = 8'h01;
            if (head < MAX_HEAD) begin
                next_head = head + 4'h1;
            end else begin
                next_head = 4'h0;
                {next_hi, next_md} = cyl + 16'h0001;
            end
        end
    end
endmodule : lmw_addr_step

// ### rtl/lmw_core.sv
// write command block: task file, log write, multiple write, wishbone slave
`timescale 1ns/100ps
module lmw_core #(
    parameter int LOGS    = 16,
    parameter int LOG_SEC = lmw_pkg::LOG_SECTORS
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire lmw_pkg::lmw_wb_req_t wb_req,
    output logic                      wb_ack,
    output logic [31:0]               wb_dat_o,
    output logic                      intrq,
    output logic                      media_we,
    output logic [27:0]               media_addr,
    output logic [15:0]               media_data,
    input  wire logic                 media_fault
);
    localparam int WPS = lmw_pkg::WORDS_PER_SECTOR;
    localparam int MW  = $clog2(LOGS * LOG_SEC * WPS);

    lmw_pkg::lmw_state_t state;
    logic [7:0]  feat, feat_prev, cnt, cnt_prev, lo, lo_prev, md, md_prev, hi, device;
    logic [7:0]  err, status, mult;
    logic [15:0] ro_mask, sup_mask;       // per-log read-only / supported flags
    logic [15:0] remaining;               // sectors still to move
    logic [8:0]  word_cnt;                // words inside current sector
    logic [7:0]  blk_cnt;                 // sectors inside current block
    logic [7:0]  cmd;
    logic [7:0]  nlo, nmd, nhi;
    logic [3:0]  nhead;
    logic [15:0] log_mem [LOGS*LOG_SEC*WPS];
    logic [MW-1:0] log_ptr;
    logic        acc, wr, first_sec, step;

    assign acc = wb_req.cyc && wb_req.stb && !wb_ack;
    assign wr  = acc && wb_req.we;
    // address steps on the first word of each later sector, so a fault between
    // sectors leaves the registers on the last sector fully taken
    assign step = state == lmw_pkg::LMW_XFER && cmd != lmw_pkg::CMD_WRITE_LOG && wr
                  && !media_fault && wb_req.adr == lmw_pkg::OFS_DATA
                  && word_cnt == 9'h000 && !first_sec;

    lmw_addr_step u_step (
        .lba_mode  (device[lmw_pkg::DEV_LBA_BIT]),
        .addr_lo   (lo),
        .addr_md   (md),
        .addr_hi   (hi),
        .head      (device[3:0]),
        .next_lo   (nlo),
        .next_md   (nmd),
        .next_hi   (nhi),
        .next_head (nhead)
    );

    // single-cycle ack, one cycle after stb; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack <= 1'b0;
        end else begin
            wb_ack <= acc;
        end
    end

    // read mux registered at the request edge so data and ack stand together
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h00000000;
        end else if (acc) begin
            case (wb_req.adr)
                lmw_pkg::OFS_COUNT:   wb_dat_o <= {24'h000000, cnt};
                lmw_pkg::OFS_ADDR_LO: wb_dat_o <= {24'h000000, lo};
                lmw_pkg::OFS_ADDR_MD: wb_dat_o <= {24'h000000, md};
                lmw_pkg::OFS_ADDR_HI: wb_dat_o <= {24'h000000, hi};
                lmw_pkg::OFS_DEVICE:  wb_dat_o <= {24'h000000, device};
                lmw_pkg::OFS_ERROR:   wb_dat_o <= {24'h000000, err};
                lmw_pkg::OFS_STATUS:  wb_dat_o <= {24'h000000, status};
                lmw_pkg::OFS_MULT:    wb_dat_o <= {24'h000000, mult};
                lmw_pkg::OFS_LOGCTL:  wb_dat_o <= {sup_mask, ro_mask};
                default:              wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // configuration registers written only while idle
    always_ff @(posedge clk) begin
        if (rst) begin
            mult     <= lmw_pkg::MULT_RST;
            ro_mask  <= 16'h0001;             // directory log is read only
            sup_mask <= 16'hFFFF;
        end else if (wr && state == lmw_pkg::LMW_IDLE) begin
            if (wb_req.adr == lmw_pkg::OFS_MULT && wb_req.sel[0] && wb_req.dat[7:0] != 8'h00)
                mult <= wb_req.dat[7:0];
            if (wb_req.adr == lmw_pkg::OFS_LOGCTL && wb_req.sel[0])
                ro_mask[7:0] <= wb_req.dat[7:0];
            if (wb_req.adr == lmw_pkg::OFS_LOGCTL && wb_req.sel[1])
                ro_mask[15:8] <= wb_req.dat[15:8];
            if (wb_req.adr == lmw_pkg::OFS_LOGCTL && wb_req.sel[2])
                sup_mask[7:0] <= wb_req.dat[23:16];
            if (wb_req.adr == lmw_pkg::OFS_LOGCTL && wb_req.sel[3])
                sup_mask[15:8] <= wb_req.dat[31:24];
        end
    end

    // log page writes: data word stored at a running pointer
    always_ff @(posedge clk) begin
        if (state == lmw_pkg::LMW_XFER && cmd == lmw_pkg::CMD_WRITE_LOG && wr
            && wb_req.adr == lmw_pkg::OFS_DATA)
            log_mem[log_ptr] <= wb_req.dat[15:0];
    end

    // media write strobe per received word of a multiple write
    always_ff @(posedge clk) begin
        if (rst) begin
            media_we   <= 1'b0;
            media_addr <= 28'h0000000;
            media_data <= 16'h0000;
        end else begin
            media_we <= state == lmw_pkg::LMW_XFER && cmd != lmw_pkg::CMD_WRITE_LOG
                        && wr && wb_req.adr == lmw_pkg::OFS_DATA;
            if (wr && wb_req.adr == lmw_pkg::OFS_DATA) begin
                media_addr <= step ? {nhead, nhi, nmd, nlo} : {device[3:0], hi, md, lo};
                media_data <= wb_req.dat[15:0];
            end
        end
    end

    // command state machine and task file
    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= lmw_pkg::LMW_IDLE;
            {feat, feat_prev, cnt, cnt_prev} <= 32'h00000000;
            {lo, lo_prev, md, md_prev, hi}   <= 40'h0000000000;
            device    <= 8'h00;
            cmd       <= 8'h00;
            err       <= 8'h00;
            status    <= lmw_pkg::STATUS_RST;
            remaining <= 16'h0000;
            word_cnt  <= 9'h000;
            blk_cnt   <= 8'h00;
            log_ptr   <= '0;
            intrq     <= 1'b0;
            first_sec <= 1'b0;
        end else begin
            intrq <= 1'b0;
            case (state)
                lmw_pkg::LMW_IDLE: begin
                    if (wr && wb_req.sel[0]) begin
                        case (wb_req.adr)
                            lmw_pkg::OFS_FEAT: begin
                                feat_prev <= feat;
                                feat      <= wb_req.dat[7:0];
                            end
                            lmw_pkg::OFS_COUNT: begin
                                cnt_prev <= cnt;
                                cnt      <= wb_req.dat[7:0];
                            end
                            lmw_pkg::OFS_ADDR_LO: begin
                                lo_prev <= lo;
                                lo      <= wb_req.dat[7:0];
                            end
                            lmw_pkg::OFS_ADDR_MD: begin
                                md_prev <= md;
                                md      <= wb_req.dat[7:0];
                            end
                            lmw_pkg::OFS_ADDR_HI: hi <= wb_req.dat[7:0];
                            lmw_pkg::OFS_DEVICE:  device <= wb_req.dat[7:0];
                            lmw_pkg::OFS_CMD: begin
                                cmd <= wb_req.dat[7:0];
                                err <= 8'h00;
                                status <= 8'h00;
                                status[lmw_pkg::ST_BSY_BIT] <= 1'b1;
                                state <= lmw_pkg::LMW_ABRT;
                                word_cnt <= 9'h000;
                                blk_cnt  <= 8'h00;
                                first_sec <= 1'b1;
                                if (wb_req.dat[7:0] == lmw_pkg::CMD_WRITE_LOG) begin
                                    // log number in lo, first log sector {md_prev,md}
                                    remaining <= {cnt_prev, cnt};
                                    log_ptr <= MW'(lo) * MW'(LOG_SEC * WPS);
                                    if (!(lo < 8'(LOGS)) || !sup_mask[lo[3:0]]
                                        || {cnt_prev, cnt} == 16'h0000
                                        || {md_prev, md} != 16'h0000) begin
                                        state <= lmw_pkg::LMW_ABRT;
                                    end else if (ro_mask[lo[3:0]]) begin
                                        state <= lmw_pkg::LMW_ABRT;
                                    end else if ({cnt_prev, cnt} > 16'(LOG_SEC)) begin
                                        state <= lmw_pkg::LMW_ABRT;
                                    end else begin
                                        state <= lmw_pkg::LMW_XFER;
                                    end
                                end else if (wb_req.dat[7:0] == lmw_pkg::CMD_WRITE_MULT) begin
                                    remaining <= (cnt == 8'h00) ? 16'(lmw_pkg::MULT_ZERO_COUNT)
                                                                : {8'h00, cnt};
                                    state <= lmw_pkg::LMW_XFER;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                lmw_pkg::LMW_XFER: begin
                    status[lmw_pkg::ST_BSY_BIT] <= 1'b0;
                    status[lmw_pkg::ST_DRQ_BIT] <= 1'b1;
                    // a fault ends the command at once; count keeps untransferred sectors
                    if (media_fault) begin
                        state <= lmw_pkg::LMW_ABRT;
                    end else if (wr && wb_req.adr == lmw_pkg::OFS_DATA) begin
                        log_ptr <= log_ptr + MW'(1);
                        // address registers move to a sector only once its data starts
                        if (step) begin
                            lo          <= nlo;
                            md          <= nmd;
                            hi          <= nhi;
                            device[3:0] <= nhead;
                        end
                        if (word_cnt == 9'(WPS - 1)) begin
                            word_cnt  <= 9'h000;
                            remaining <= remaining - 16'h0001;
                            cnt       <= 8'(remaining - 16'h0001);
                            first_sec <= 1'b0;
                            // one interrupt per block: one sector for log, mult for c5
                            if (cmd == lmw_pkg::CMD_WRITE_LOG || blk_cnt == mult - 8'h01
                                || remaining == 16'h0001) begin
                                intrq   <= 1'b1;
                                blk_cnt <= 8'h00;
                            end else begin
                                blk_cnt <= blk_cnt + 8'h01;
                            end
                            if (remaining == 16'h0001)
                                state <= lmw_pkg::LMW_DONE;
                        end else begin
                            word_cnt <= word_cnt + 9'h001;
                        end
                    end
                end
                lmw_pkg::LMW_DONE: begin
                    status <= lmw_pkg::STATUS_RST;
                    state  <= lmw_pkg::LMW_IDLE;
                end
                lmw_pkg::LMW_ABRT: begin
                    err[lmw_pkg::ERR_ABT_BIT]    <= 1'b1;
                    status <= lmw_pkg::STATUS_RST;
                    status[lmw_pkg::ST_ERR_BIT] <= 1'b1;
                    intrq  <= 1'b1;
                    state  <= lmw_pkg::LMW_IDLE;
                end
                default: state <= lmw_pkg::LMW_IDLE;
            endcase
        end
    end

    // abort and opcode checks
    chk_abort_flags: assert property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_ABRT |=> err[lmw_pkg::ERR_ABT_BIT] && status[lmw_pkg::ST_ERR_BIT])
        else $error("abort did not flag error");
    chk_bad_opcode: assert property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_IDLE && wr && wb_req.adr == lmw_pkg::OFS_CMD && wb_req.sel[0]
        && wb_req.dat[7:0] != lmw_pkg::CMD_WRITE_LOG
        && wb_req.dat[7:0] != lmw_pkg::CMD_WRITE_MULT
        |=> state == lmw_pkg::LMW_ABRT)
        else $error("unknown opcode not aborted");
    chk_fault_abort: assert property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_XFER && media_fault |=> state == lmw_pkg::LMW_ABRT)
        else $error("media fault did not abort");

    // log command checks
    chk_ro_abort: assert property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_IDLE && wr && wb_req.adr == lmw_pkg::OFS_CMD && wb_req.sel[0]
        && wb_req.dat[7:0] == lmw_pkg::CMD_WRITE_LOG && ro_mask[lo[3:0]]
        |=> state == lmw_pkg::LMW_ABRT)
        else $error("read-only log write not aborted");
    chk_log_size: assert property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_IDLE && wr && wb_req.adr == lmw_pkg::OFS_CMD && wb_req.sel[0]
        && wb_req.dat[7:0] == lmw_pkg::CMD_WRITE_LOG && {cnt_prev, cnt} > 16'(LOG_SEC)
        |=> state == lmw_pkg::LMW_ABRT)
        else $error("oversize log write not aborted");
    chk_log_start: assert property (@(posedge clk) disable iff (rst)
        $rose(state == lmw_pkg::LMW_XFER) && cmd == lmw_pkg::CMD_WRITE_LOG
        |-> int'(log_ptr) == int'(lo) * LOG_SEC * WPS)
        else $error("log data not started at first sector");
    chk_log_no_media: assert property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_XFER && cmd == lmw_pkg::CMD_WRITE_LOG |=> !media_we)
        else $error("log data reached the media");

    // multiple write, interrupt source and completion checks
    chk_zero_count: assert property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_IDLE && wr && wb_req.adr == lmw_pkg::OFS_CMD && wb_req.sel[0]
        && wb_req.dat[7:0] == lmw_pkg::CMD_WRITE_MULT && cnt == 8'h00
        |=> remaining == 16'h0100)
        else $error("zero count not taken as 256");
    chk_media_commit: assert property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_XFER && cmd == lmw_pkg::CMD_WRITE_MULT && wr
        && wb_req.adr == lmw_pkg::OFS_DATA |=> media_we && media_data == $past(wb_req.dat[15:0]))
        else $error("data word not committed");
    chk_mid_block_quiet: assert property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_XFER && cmd == lmw_pkg::CMD_WRITE_MULT && !media_fault && wr
        && wb_req.adr == lmw_pkg::OFS_DATA && word_cnt == 9'(WPS - 1)
        && blk_cnt != mult - 8'h01 && remaining != 16'h0001 |=> !intrq)
        else $error("interrupt inside a block");
    chk_irq_source: assert property (@(posedge clk) disable iff (rst)
        intrq |-> $past(state) == lmw_pkg::LMW_ABRT || $past(word_cnt) == 9'(WPS - 1))
        else $error("interrupt without block end");
    chk_done_count: assert property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_DONE |-> remaining == 16'h0000)
        else $error("sectors left at completion");
    chk_done_cnt_reg: assert property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_DONE |-> cnt == 8'h00)
        else $error("count register not zero at completion");

    // bus and configuration checks
    chk_ack_pulse: assert property (@(posedge clk) disable iff (rst)
        wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    chk_cfg_frozen: assert property (@(posedge clk) disable iff (rst)
        state != lmw_pkg::LMW_IDLE |=> $stable(mult) && $stable(ro_mask) && $stable(sup_mask))
        else $error("configuration changed during a command");

    // scenario covers
    cov_log_ok:  cover property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_DONE && cmd == lmw_pkg::CMD_WRITE_LOG);
    cov_mult_ok: cover property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_DONE && cmd == lmw_pkg::CMD_WRITE_MULT);
    cov_abort:   cover property (@(posedge clk) disable iff (rst) state == lmw_pkg::LMW_ABRT);
    cov_zero_count: cover property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_XFER && remaining == 16'h0100);
    cov_fault:   cover property (@(posedge clk) disable iff (rst)
        state == lmw_pkg::LMW_XFER && media_fault);
endmodule : lmw_core

// ### verif/lmw_host_model.sv
// host model: classic wishbone master issuing task-file accesses
`timescale 1ns/100ps
module lmw_host_model (
    input  wire logic            clk,
    output lmw_pkg::lmw_wb_req_t wb_req,
    input  wire logic            wb_ack
);
    initial wb_req = '0;

    // one classic cycle: held until ack is sampled high, then released
    task automatic xfer(input logic [7:0] adr, input logic [31:0] dat, input logic we);
        @(posedge clk);
        wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hF, dat: dat};
        do @(posedge clk); while (wb_ack !== 1'h1);
        // released lines show the inverse so stale values never look valid
        wb_req <= '{cyc: 1'h0, stb: 1'h0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~dat};
    endtask : xfer
endmodule : lmw_host_model

// ### verif/test_log_and_multiple_write_commands.sv
// testbench: log write and multiple write command block
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, s); end end
module test_log_and_multiple_write_commands;
    logic                 clk = 1'h0;
    logic                 rst = 1'h1;
    logic                 media_fault = 1'h0;
    lmw_pkg::lmw_wb_req_t wb_req;
    logic                 wb_ack, intrq, media_we;
    logic [31:0]          wb_dat_o, seed, e_v, m_v;
    logic [27:0]          media_addr, last_addr;
    logic [15:0]          media_data, d_v;
    logic [31:0]          rd_q[$], mk_q[$];
    logic [15:0]          dat_q[$];
    int                   bad_count = 0, n_tests = 0, irq_n = 0, mwe_n = 0, i0, m0;
    logic [7:0]           lg_t[5] = '{8'h00, 8'h02, 8'h02, 8'h02, 8'h10};
    logic [15:0]          cnt_t[5] = '{16'h0001, 16'h0005, 16'h0000, 16'h0001, 16'h0001};
    logic [15:0]          sec_t[5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000};

    always #20 clk = ~clk;

    lmw_core DUT (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
        .intrq(intrq), .media_we(media_we), .media_addr(media_addr), .media_data(media_data),
        .media_fault(media_fault));
    lmw_host_model host (.clk(clk), .wb_req(wb_req), .wb_ack(wb_ack));

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs

    // watcher: read answers, media words and interrupt pulses
    always @(posedge clk) begin
        if (wb_ack === 1'h1 && wb_req.cyc === 1'h1 && wb_req.we === 1'h0) begin
            e_v = rd_q.pop_front();
            m_v = mk_q.pop_front();
            `CHK("read data", e_v & m_v, wb_dat_o & m_v)
        end
        if (media_we === 1'h1) begin
            mwe_n++;
            last_addr = media_addr;
            d_v = dat_q.pop_front();
            `CHK("media data", d_v, media_data)
        end
        if (intrq === 1'h1) irq_n++;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(a, d, 1'h1);
    endtask : wr
    // expected value noted before the read goes out
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rd_q.push_back(e);
        mk_q.push_back(m);
        host.xfer(a, 32'h0, 1'h0);
    endtask : rd
    // random sector data, expected on the media side only when it goes there
    task automatic sectors(input int n, input logic to_media);
        for (int i = 0; i < n * 256; i++) begin
            seed = xs(seed);
            if (to_media) dat_q.push_back(seed[15:0]);
            wr(lmw_pkg::OFS_DATA, {16'h0, seed[15:0]});
        end
    endtask : sectors
    task automatic settle;
        repeat (4) @(posedge clk);
    endtask : settle
    // count and start sector go high byte first, then low byte
    task automatic log_cmd(input logic [7:0] lg, input logic [15:0] cnt, input logic [15:0] sec);
        wr(lmw_pkg::OFS_COUNT, {24'h0, cnt[15:8]});
        wr(lmw_pkg::OFS_COUNT, {24'h0, cnt[7:0]});
        wr(lmw_pkg::OFS_ADDR_MD, {24'h0, sec[15:8]});
        wr(lmw_pkg::OFS_ADDR_MD, {24'h0, sec[7:0]});
        wr(lmw_pkg::OFS_ADDR_LO, {24'h0, lg});
        wr(lmw_pkg::OFS_CMD, {24'h0, lmw_pkg::CMD_WRITE_LOG});
    endtask : log_cmd
    task automatic aborted(input int ib);
        settle();
        `CHK("abort irq", ib + 1, irq_n)
        rd(lmw_pkg::OFS_ERROR, 32'h04, 32'hFF);
        rd(lmw_pkg::OFS_STATUS, 32'h01, 32'h01);
    endtask : aborted

    task automatic report_and_stop;
        if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // hang guard, well beyond the few thousand cycles the run needs
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        seed = 32'hB911;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        rd(lmw_pkg::OFS_STATUS, 32'h50, 32'hFF);
        rd(lmw_pkg::OFS_ERROR, 32'h00, 32'hFF);
        rd(lmw_pkg::OFS_MULT, 32'h01, 32'hFF);
        rd(lmw_pkg::OFS_LOGCTL, 32'hFFFF0001, 32'hFFFFFFFF);
        rd(8'h30, 32'h0, 32'hFFFFFFFF);
        // bad log requests: read-only, too long, zero, bad sector, bad log
        for (int k = 0; k < 5; k++) begin
            i0 = irq_n;
            log_cmd(lg_t[k], cnt_t[k], sec_t[k]);
            aborted(i0);
        end
        // log whose feature set is switched off
        wr(lmw_pkg::OFS_LOGCTL, 32'hFFF70001);
        i0 = irq_n;
        log_cmd(8'h03, 16'h0001, 16'h0000);
        aborted(i0);
        wr(lmw_pkg::OFS_LOGCTL, 32'hFFFF0001);
        i0 = irq_n;
        wr(lmw_pkg::OFS_CMD, {24'h0, lmw_pkg::CMD_WRITE_MEXT});
        aborted(i0);
        // full-size log write: one pulse per sector, nothing to the media
        i0 = irq_n;
        m0 = mwe_n;
        log_cmd(8'h02, 16'h0004, 16'h0000);
        sectors(4, 1'h0);
        settle();
        `CHK("log irq", i0 + 4, irq_n)
        `CHK("log media", m0, mwe_n)
        rd(lmw_pkg::OFS_STATUS, 32'h50, 32'hFF);
        // lba write of two sectors in one block, low address byte wraps
        wr(lmw_pkg::OFS_MULT, 32'h02);
        wr(lmw_pkg::OFS_COUNT, 32'h02);
        wr(lmw_pkg::OFS_ADDR_LO, 32'hFF);
        wr(lmw_pkg::OFS_ADDR_MD, 32'h45);
        wr(lmw_pkg::OFS_ADDR_HI, 32'h23);
        wr(lmw_pkg::OFS_DEVICE, 32'h41);
        i0 = irq_n;
        m0 = mwe_n;
        wr(lmw_pkg::OFS_CMD, {24'h0, lmw_pkg::CMD_WRITE_MULT});
        rd(lmw_pkg::OFS_STATUS, 32'h08, 32'h08);
        sectors(1, 1'h1);
        settle();
        `CHK("lba first", 28'h12345FF, last_addr)
        `CHK("mid block irq", i0, irq_n)
        sectors(1, 1'h1);
        settle();
        `CHK("lba last", 28'h1234600, last_addr)
        `CHK("block irq", i0 + 1, irq_n)
        `CHK("media words", m0 + 512, mwe_n)
        rd(lmw_pkg::OFS_COUNT, 32'h00, 32'hFF);
        rd(lmw_pkg::OFS_ADDR_LO, 32'h00, 32'hFF);
        rd(lmw_pkg::OFS_ADDR_MD, 32'h46, 32'hFF);
        rd(lmw_pkg::OFS_ADDR_HI, 32'h23, 32'hFF);
        rd(lmw_pkg::OFS_STATUS, 32'h50, 32'hFF);
        // chs write of count zero, media fault after the first sector
        wr(lmw_pkg::OFS_MULT, 32'h01);
        wr(lmw_pkg::OFS_COUNT, 32'h00);
        wr(lmw_pkg::OFS_ADDR_LO, 32'h01);
        wr(lmw_pkg::OFS_ADDR_MD, 32'h00);
        wr(lmw_pkg::OFS_ADDR_HI, 32'h00);
        wr(lmw_pkg::OFS_DEVICE, 32'h00);
        wr(lmw_pkg::OFS_CMD, {24'h0, lmw_pkg::CMD_WRITE_MULT});
        sectors(1, 1'h1);
        settle();
        i0 = irq_n;
        media_fault <= 1'h1;
        repeat (3) @(posedge clk);
        media_fault <= 1'h0;
        aborted(i0);
        rd(lmw_pkg::OFS_COUNT, 32'hFF, 32'hFF);
        `CHK("chs addr", 28'h0000001, last_addr)
        rd(lmw_pkg::OFS_ADDR_LO, 32'h01, 32'hFF);
        settle();
        report_and_stop();
    end
endmodule : test_log_and_multiple_write_commands
